/* orph_defines.vh */
// Constants for the offload ring packet header block
`ifndef ORPH_DEFINES_VH
`define ORPH_DEFINES_VH
`define ORPH_PROTO_ICMP     8'h01
`define ORPH_PROTO_IGMP     8'h02
`define ORPH_PROTO_TCP      8'h06
`define ORPH_PROTO_UDP      8'h11
`define ORPH_PROTO_NONIP    8'hFF
`define ORPH_ETYPE_IPV4     16'h0800
`define ORPH_ETYPE_IPV6     16'h86DD
`define ORPH_ETYPE_PPP_DISC 16'h8863
`define ORPH_ETYPE_PPP_SESS 16'h8864
`define ORPH_ETYPE_MIN      16'h0600
`define ORPH_PPP_PROTO_IP   16'h0021
`define ORPH_OFS_NPR_HI     12'h000
`define ORPH_OFS_NPR_LO     12'h001
`define ORPH_OFS_LEN_HI     12'h002
`define ORPH_OFS_LEN_LO     12'h003
`define ORPH_OFS_PROTO      12'h004
`define ORPH_OFS_FLAGS      12'h005
`define ORPH_OFS_DATA       12'h006
`define ORPH_PPPOE_BIT      7
`define ORPH_TAG_BYTES      5'h04
`define ORPH_LLC_BYTES      5'h08
`define ORPH_PPPOE_BYTES    5'h08
`define ORPH_PAGE_LSB       8'h00
`define ORPH_FIFO_DEPTH     2'h2
`endif

/* orph_skid_fifo.v */
// Two-entry buffer between the transmit ring reader and the MAC
`timescale 1ns/1ns
`default_nettype none
`include "orph_defines.vh"
module orph_skid_fifo (
    // Clock and reset
    input  wire       sys_clk_in,
    input  wire       sys_rst_in,
    // Fill side
    input  wire       in_valid_in,
    input  wire [8:0] in_data_in,
    output wire       in_ready_out,
    // Drain side
    output wire       out_valid_out,
    output wire [8:0] out_data_out,
    input  wire       out_ready_in
);
    reg [8:0] mem_r [0:1];
    reg       wr_ptr_r;
    reg       rd_ptr_r;
    reg [1:0] count_r;
    wire      push;
    wire      pop;

    assign in_ready_out  = (count_r != `ORPH_FIFO_DEPTH);
    assign out_valid_out = (count_r != 2'h0);
    assign out_data_out  = mem_r[rd_ptr_r];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    always @(posedge sys_clk_in) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push & ~pop) begin
                count_r <= count_r + 2'h1;
            end else if (pop & ~push) begin
                count_r <= count_r - 2'h1;
            end
        end
    end
endmodule // orph_skid_fifo
`default_nettype wire

/* orph_packet_headers.v */
// Receive header builder and transmit ring reader of the offload engine
// Behaviour
// - Non-IP receive length counts bytes from destination address to data end, both modes.
// - Non-transparent mode: LLC, raw 802.3, IPv6, PPPoE frames get protocol 0xFF.
// - Transparent mode: PPPoE discovery non-IP; session non-IP unless PPP protocol is 0021.
// - Software enqueues; layer-4 unit dequeues following each header's next-packet link.
// - Dequeued transmit packets are moved by DMA toward the MAC transmit buffer.
// - Transmit header bytes 0x00/0x01 hold the 16-bit next-packet page, high first.
// - Byte 0x04 protocol code ICMP/IGMP/UDP/TCP selects the engine's processing.
// - PPPoE flag with LLC enable clear means 8 extra bytes are a PPPoE header.
// - Software zeroes TCP checksums; the engine inserts computed checksums.
// - With ring wrap enabled, flag wrapping packets and report pages before ring end.
// - After each transmit packet, advance head and add its pages to free count.
`timescale 1ns/1ns
`default_nettype none
`include "orph_defines.vh"
module orph_packet_headers (
    // Clock and reset
    input  wire        sys_clk_in,
    input  wire        sys_rst_in,
    // Layer-2 and ring configuration
    input  wire        transparent_mode_in,
    input  wire        rx_ring_wrap_enable_in,
    input  wire [15:0] rx_ring_end_page_in,
    input  wire        tx_tag_enable_in,
    input  wire        tx_llc_header_enable_in,
    // Receive frame summary
    input  wire        rx_frame_valid_in,
    input  wire [15:0] rx_etype_in,
    input  wire [15:0] rx_ppp_proto_in,
    input  wire [7:0]  rx_ip_proto_in,
    input  wire [11:0] rx_da_length_in,
    input  wire [11:0] rx_ip_length_in,
    input  wire [15:0] rx_start_page_in,
    input  wire [7:0]  rx_page_count_in,
    input  wire [15:0] rx_next_page_in,
    // Receive header fields
    output reg         rx_hdr_valid_out,
    output reg  [15:0] rx_next_packet_pointer_out,
    output reg         rx_ring_boundary_cross_flag_out,
    output reg  [2:0]  rx_pages_before_ring_end_out,
    output reg  [11:0] rx_length_out,
    output reg  [7:0]  rx_protocol_out,
    // Transmit ring control
    input  wire        tx_enable_in,
    input  wire        tx_ring_init_in,
    input  wire [15:0] tx_ring_start_page_in,
    input  wire [15:0] tx_ring_end_page_in,
    input  wire [15:0] tx_tail_pointer_in,
    input  wire        tx_enqueue_in,
    input  wire [7:0]  tx_enqueue_pages_in,
    output reg  [15:0] tx_ring_head_pointer_out,
    output reg  [7:0]  tx_ring_free_pages_out,
    output wire        tx_busy_out,
    // Transmit ring memory read
    output wire        tx_mem_rd_out,
    output wire [23:0] tx_mem_addr_out,
    input  wire [7:0]  tx_mem_data_in,
    // Parsed transmit header
    output reg  [7:0]  tx_protocol_out,
    output reg         tx_pppoe_out,
    output reg  [4:0]  tx_l2_extra_out,
    output reg         tx_csum_insert_out,
    output reg         tx_config_error_out,
    // MAC transmit byte stream
    output wire        tx_mac_valid_out,
    output wire [7:0]  tx_mac_data_out,
    output wire        tx_mac_last_out,
    input  wire        tx_mac_ready_in
);
    localparam ST_IDLE = 2'b00;
    localparam ST_HDR  = 2'b01;
    localparam ST_DATA = 2'b10;
    localparam ST_DONE = 2'b11;

    // Receive classification
    reg         rx_non_ip;
    reg  [16:0] rx_last_page;
    reg  [15:0] rx_before_end;
    always @* begin
        rx_non_ip = (rx_etype_in < `ORPH_ETYPE_MIN) ||
                    (rx_etype_in == `ORPH_ETYPE_IPV6) ||
                    (rx_etype_in == `ORPH_ETYPE_PPP_DISC);
        if (rx_etype_in == `ORPH_ETYPE_PPP_SESS) begin
            rx_non_ip = ~transparent_mode_in ||
                        (rx_ppp_proto_in != `ORPH_PPP_PROTO_IP);
        end else if (rx_etype_in != `ORPH_ETYPE_IPV4) begin
            rx_non_ip = 1'b1;
        end
        rx_last_page  = {1'b0, rx_start_page_in} + {9'h000, rx_page_count_in} - 17'h00001;
        rx_before_end = rx_ring_end_page_in - rx_start_page_in + 16'h0001;
    end

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rx_hdr_valid_out                <= 1'b0;
            rx_next_packet_pointer_out      <= 16'h0000;
            rx_ring_boundary_cross_flag_out <= 1'b0;
            rx_pages_before_ring_end_out    <= 3'h0;
            rx_length_out                   <= 12'h000;
            rx_protocol_out                 <= 8'h00;
        end else begin
            rx_hdr_valid_out <= rx_frame_valid_in;
            if (rx_frame_valid_in) begin
                rx_next_packet_pointer_out <= rx_next_page_in;
                // Undefined fields are driven as zero when wrap is off
                if (rx_ring_wrap_enable_in &&
                    (rx_last_page > {1'b0, rx_ring_end_page_in})) begin
                    rx_ring_boundary_cross_flag_out <= 1'b1;
                    rx_pages_before_ring_end_out    <= rx_before_end[2:0];
                end else begin
                    rx_ring_boundary_cross_flag_out <= 1'b0;
                    rx_pages_before_ring_end_out    <= 3'h0;
                end
                if (rx_non_ip) begin
                    rx_protocol_out <= `ORPH_PROTO_NONIP;
                    rx_length_out   <= rx_da_length_in;
                end else begin
                    rx_protocol_out <= rx_ip_proto_in;
                    rx_length_out   <= transparent_mode_in ? rx_da_length_in
                                                           : rx_ip_length_in;
                end
            end
        end
    end

    // Transmit ring reader
    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [11:0] idx_r;
    reg  [11:0] cap_idx_r;
    reg         rd_pend_r;
    reg  [15:0] next_ptr_r;
    reg  [11:0] len_r;
    reg  [15:0] pkt_pages;
    reg  [7:0]  free_add;
    reg  [7:0]  free_sub;
    wire        fifo_in_ready;
    wire [8:0]  fifo_out_data;
    wire [11:0] data_end;
    wire        data_last;
    wire        issue;

    assign data_end        = `ORPH_OFS_DATA + len_r;
    assign data_last       = (cap_idx_r == data_end - 12'h001);
    // One read in flight keeps the buffer from ever being overrun
    assign issue           = ~rd_pend_r &&
                             (((state_r == ST_HDR) && (idx_r <= `ORPH_OFS_FLAGS)) ||
                              ((state_r == ST_DATA) && fifo_in_ready &&
                               (idx_r < data_end)));
    assign tx_mem_rd_out   = issue;
    assign tx_mem_addr_out = {tx_ring_head_pointer_out, `ORPH_PAGE_LSB} + {12'h000, idx_r};
    assign tx_busy_out     = (state_r != ST_IDLE);

    always @* begin
        if (next_ptr_r >= tx_ring_head_pointer_out) begin
            pkt_pages = next_ptr_r - tx_ring_head_pointer_out;
        end else begin
            pkt_pages = (tx_ring_end_page_in - tx_ring_head_pointer_out + 16'h0001) +
                        (next_ptr_r - tx_ring_start_page_in);
        end
        free_add  = (state_r == ST_DONE) ? pkt_pages[7:0] : 8'h00;
        free_sub  = tx_enqueue_in ? tx_enqueue_pages_in : 8'h00;
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (tx_enable_in && (tx_ring_head_pointer_out != tx_tail_pointer_in)) begin
                    state_nxt = ST_HDR;
                end
            end
            ST_HDR: begin
                if (rd_pend_r && (cap_idx_r == `ORPH_OFS_FLAGS)) begin
                    state_nxt = (len_r == 12'h000) ? ST_DONE : ST_DATA;
                end
            end
            ST_DATA: begin
                if (rd_pend_r && data_last) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state_r                  <= ST_IDLE;
            idx_r                    <= 12'h000;
            cap_idx_r                <= 12'h000;
            rd_pend_r                <= 1'b0;
            next_ptr_r               <= 16'h0000;
            len_r                    <= 12'h000;
            tx_ring_head_pointer_out <= 16'h0000;
            tx_ring_free_pages_out   <= 8'h00;
            tx_protocol_out          <= 8'h00;
            tx_pppoe_out             <= 1'b0;
            tx_l2_extra_out          <= 5'h00;
            tx_csum_insert_out       <= 1'b0;
            tx_config_error_out      <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            rd_pend_r <= issue;
            if (issue) begin
                cap_idx_r <= idx_r;
                idx_r     <= idx_r + 12'h001;
            end
            if (tx_ring_init_in) begin
                tx_ring_head_pointer_out <= tx_ring_start_page_in;
                tx_ring_free_pages_out   <= tx_ring_end_page_in[7:0] -
                                            tx_ring_start_page_in[7:0];
            end else begin
                tx_ring_free_pages_out <= tx_ring_free_pages_out + free_add - free_sub;
                if (state_r == ST_DONE) begin
                    tx_ring_head_pointer_out <= next_ptr_r;
                end
            end
            if (state_r == ST_IDLE) begin
                idx_r <= `ORPH_OFS_NPR_HI;
            end
            if ((state_r == ST_HDR) && rd_pend_r) begin
                case (cap_idx_r)
                    `ORPH_OFS_NPR_HI: next_ptr_r[15:8] <= tx_mem_data_in;
                    `ORPH_OFS_NPR_LO: next_ptr_r[7:0]  <= tx_mem_data_in;
                    `ORPH_OFS_LEN_HI: len_r[11:8]      <= tx_mem_data_in[3:0];
                    `ORPH_OFS_LEN_LO: len_r[7:0]       <= tx_mem_data_in;
                    `ORPH_OFS_PROTO: begin
                        tx_protocol_out    <= tx_mem_data_in;
                        tx_csum_insert_out <= (tx_mem_data_in == `ORPH_PROTO_TCP);
                    end
                    `ORPH_OFS_FLAGS: begin
                        tx_pppoe_out <= tx_mem_data_in[`ORPH_PPPOE_BIT];
                        // PPPoE with LLC enable set cannot be parsed reliably
                        tx_config_error_out <= tx_mem_data_in[`ORPH_PPPOE_BIT] &
                                               tx_llc_header_enable_in;
                        if (tx_mem_data_in[`ORPH_PPPOE_BIT] && !tx_llc_header_enable_in) begin
                            tx_l2_extra_out <= `ORPH_PPPOE_BYTES +
                                (tx_tag_enable_in ? `ORPH_TAG_BYTES : 5'h00);
                        end else begin
                            tx_l2_extra_out <=
                                (tx_tag_enable_in ? `ORPH_TAG_BYTES : 5'h00) +
                                (tx_llc_header_enable_in ? `ORPH_LLC_BYTES : 5'h00);
                        end
                    end
                    default: begin
                        tx_protocol_out <= tx_protocol_out;
                    end
                endcase
            end
        end
    end

    orph_skid_fifo u_buf (
        .sys_clk_in    (sys_clk_in),
        .sys_rst_in    (sys_rst_in),
        .in_valid_in   ((state_r == ST_DATA) && rd_pend_r),
        .in_data_in    ({data_last, tx_mem_data_in}),
        .in_ready_out  (fifo_in_ready),
        .out_valid_out (tx_mac_valid_out),
        .out_data_out  (fifo_out_data),
        .out_ready_in  (tx_mac_ready_in)
    );

    assign tx_mac_data_out = fifo_out_data[7:0];
    assign tx_mac_last_out = fifo_out_data[8];
endmodule // orph_packet_headers
`default_nettype wire

/* orph_packet_headers_sva.sv */
// Assertion checker for the offload ring packet header block
`timescale 1ns/1ns
`default_nettype none
module orph_packet_headers_sva (
    // Clock, reset and modes
    input wire logic        sys_clk_in,
    input wire logic        sys_rst_in,
    input wire logic        transparent_mode_in,
    input wire logic        rx_ring_wrap_enable_in,
    // Receive side
    input wire logic        rx_frame_valid_in,
    input wire logic [15:0] rx_etype_in,
    input wire logic [15:0] rx_ppp_proto_in,
    input wire logic [7:0]  rx_ip_proto_in,
    input wire logic [11:0] rx_da_length_in,
    input wire logic        rx_hdr_valid_out,
    input wire logic        rx_ring_boundary_cross_flag_out,
    input wire logic [11:0] rx_length_out,
    input wire logic [7:0]  rx_protocol_out,
    // Transmit side
    input wire logic        tx_enable_in,
    input wire logic [15:0] tx_tail_pointer_in,
    input wire logic [15:0] tx_ring_head_pointer_out,
    input wire logic        tx_busy_out,
    input wire logic        tx_mem_rd_out,
    input wire logic        tx_mac_valid_out,
    input wire logic [7:0]  tx_mac_data_out,
    input wire logic        tx_mac_last_out,
    input wire logic        tx_mac_ready_in
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    rx_answer_a: assert property (
        rx_frame_valid_in |=> rx_hdr_valid_out ##1 !rx_hdr_valid_out) else $error("no header pulse");
    rx_quiet_a: assert property (
        !rx_frame_valid_in |=> !rx_hdr_valid_out) else $error("header without frame");
    rx_nonip_len_a: assert property (
        rx_hdr_valid_out && rx_protocol_out == 8'hFF |-> rx_length_out == $past(rx_da_length_in))
        else $error("non-IP length wrong");
    rx_v6_nonip_a: assert property (
        rx_frame_valid_in && rx_etype_in == 16'h86DD |=> rx_protocol_out == 8'hFF)
        else $error("IPv6 not non-IP");
    rx_session_ip_a: assert property (
        rx_frame_valid_in && transparent_mode_in && rx_etype_in == 16'h8864
        && rx_ppp_proto_in == 16'h0021 |=> rx_protocol_out == $past(rx_ip_proto_in))
        else $error("IP session frame misclassed");
    rx_nowrap_a: assert property (
        rx_frame_valid_in && !rx_ring_wrap_enable_in |=> !rx_ring_boundary_cross_flag_out)
        else $error("cross flag without wrap");
    tx_empty_stop_a: assert property (
        !tx_busy_out && (tx_ring_head_pointer_out == tx_tail_pointer_in || !tx_enable_in)
        |=> !tx_busy_out) else $error("dequeue on empty ring");
    tx_read_space_a: assert property (
        tx_mem_rd_out |-> tx_busy_out ##1 !tx_mem_rd_out) else $error("read spacing broken");
    mac_hold_a: assert property (
        tx_mac_valid_out && !tx_mac_ready_in |=> tx_mac_valid_out
        && $stable(tx_mac_data_out) && $stable(tx_mac_last_out)) else $error("stalled byte lost");
endmodule // orph_packet_headers_sva
bind orph_packet_headers orph_packet_headers_sva u_sva (.*);
`default_nettype wire

/* orph_ring_mem.sv */
// Transmit ring memory model answering the block's reads
`timescale 1ns/1ns
`default_nettype none
module orph_ring_mem (
    // Clock
    input wire logic        sys_clk_in,
    // Read port
    input wire logic        rd_in,
    input wire logic [23:0] addr_in,
    output logic     [7:0]  data_out
);
    logic [7:0] mem [0:65535];
    initial data_out = 8'h00;
    // Only the low 16 address bits are kept; rings here stay below page 0x100
    always @(posedge sys_clk_in) begin
        if (rd_in)
            data_out <= mem[addr_in[15:0]];
        else
            data_out <= ~data_out; // Not held, so stale data is never mistaken
    end
endmodule // orph_ring_mem
`default_nettype wire

/* orph_packet_headers_tb_top.sv */
// Self-checking bench for the offload ring packet header block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin err_count++; \
    $display("BAD %s exp %h got %h", nm, ex, gt); end end
module orph_packet_headers_tb_top;
    logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, transparent_mode_in = 1'b0;
    logic rx_ring_wrap_enable_in = 1'b0, tx_tag_enable_in = 1'b0, tx_llc_header_enable_in = 1'b0;
    logic rx_frame_valid_in = 1'b0, tx_enable_in = 1'b0, tx_ring_init_in = 1'b0;
    logic tx_enqueue_in = 1'b0, tx_mac_ready_in = 1'b0;
    logic [15:0] rx_etype_in = 16'h0800, rx_ppp_proto_in = 16'h0, rx_start_page_in = 16'h0;
    logic [15:0] rx_next_page_in = 16'h0123, rx_ring_end_page_in = 16'h00FF;
    logic [15:0] tx_ring_start_page_in = 16'h0010, tx_ring_end_page_in = 16'h0020;
    logic [15:0] tx_tail_pointer_in = 16'h0;
    logic [11:0] rx_da_length_in = 12'h0FC, rx_ip_length_in = 12'h0EE;
    logic [7:0] rx_ip_proto_in = 8'h11, rx_page_count_in = 8'h1, tx_enqueue_pages_in = 8'h04;
    logic [7:0] tx_mem_data_in, rx_protocol_out, tx_ring_free_pages_out, tx_protocol_out;
    logic [7:0] tx_mac_data_out;
    logic rx_hdr_valid_out, rx_ring_boundary_cross_flag_out, tx_busy_out, tx_mem_rd_out;
    logic tx_pppoe_out, tx_csum_insert_out, tx_config_error_out, tx_mac_valid_out, tx_mac_last_out;
    logic [15:0] rx_next_packet_pointer_out, tx_ring_head_pointer_out;
    logic [11:0] rx_length_out;
    logic [4:0] tx_l2_extra_out;
    logic [2:0] rx_pages_before_ring_end_out;
    logic [23:0] tx_mem_addr_out;
    int err_count = 0, n_checks = 0, cyc = 0, stall_until = 0;
    logic [8:0] exp_q[$], got_q[$];
    logic [15:0] par_q[$];

    always #4 sys_clk_in = ~sys_clk_in;
    orph_packet_headers dut (.*);
    orph_ring_mem u_mem (.sys_clk_in(sys_clk_in), .rd_in(tx_mem_rd_out),
        .addr_in(tx_mem_addr_out), .data_out(tx_mem_data_in));

    // MAC sink stalls one cycle in three, and fully at first so the buffer fills
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        tx_mac_ready_in <= #1 (cyc > stall_until) && (cyc % 3 != 0);
        if (!sys_rst_in && tx_mac_valid_out && tx_mac_ready_in) begin
            got_q.push_back({tx_mac_last_out, tx_mac_data_out});
            if (tx_mac_last_out)
                par_q.push_back({tx_protocol_out, tx_pppoe_out, tx_l2_extra_out,
                    tx_csum_insert_out, tx_config_error_out});
        end
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic step(input int n = 1);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic send_rx(input logic tm, input logic [15:0] et, pp, st, input logic [7:0] cnt);
        transparent_mode_in = tm;
        rx_etype_in = et;
        rx_ppp_proto_in = pp;
        rx_start_page_in = st;
        rx_page_count_in = cnt;
        rx_frame_valid_in = 1'b1;
        step();
        rx_frame_valid_in = 1'b0;
        `CHK("rx_valid", 1'b1, rx_hdr_valid_out)
        `CHK("rx_next", rx_next_page_in, rx_next_packet_pointer_out)
        step();
        `CHK("rx_drop", 1'b0, rx_hdr_valid_out)
    endtask

    task automatic t_rx_class;
        logic [32:0] cs [11];
        logic nonip;
        cs = '{{1'b0, 16'h05DC, 16'h0}, {1'b0, 16'h86DD, 16'h0}, {1'b0, 16'h8863, 16'h0},
            {1'b0, 16'h8864, 16'h0021}, {1'b0, 16'h0800, 16'h0}, {1'b1, 16'h0040, 16'h0},
            {1'b1, 16'h86DD, 16'h0}, {1'b1, 16'h8863, 16'h0}, {1'b1, 16'h8864, 16'h0021},
            {1'b1, 16'h8864, 16'h0057}, {1'b1, 16'h0800, 16'h0}};
        foreach (cs[i]) begin
            send_rx(cs[i][32], cs[i][31:16], cs[i][15:0], 16'h0040, 8'h02);
            nonip = !(cs[i][31:16] == 16'h0800 || (cs[i][32] && cs[i][15:0] == 16'h0021));
            `CHK("rx_proto", nonip ? 8'hFF : 8'h11, rx_protocol_out)
            `CHK("rx_len", (nonip || cs[i][32]) ? 12'h0FC : 12'h0EE, rx_length_out)
        end
    endtask

    task automatic t_rx_wrap;
        rx_ring_wrap_enable_in = 1'b1;
        send_rx(1'b0, 16'h0800, 16'h0, 16'h00FE, 8'h03);
        `CHK("rx_cross", 1'b1, rx_ring_boundary_cross_flag_out)
        `CHK("rx_before", 3'h2, rx_pages_before_ring_end_out)
        send_rx(1'b0, 16'h0800, 16'h0, 16'h0040, 8'h02);
        `CHK("rx_cross", 1'b0, rx_ring_boundary_cross_flag_out)
    endtask

    task automatic put_pkt(input logic [7:0] pg, nx, ln, pr, fl, db);
        int i;
        u_mem.mem[{pg, 8'h00}] = 8'h00;
        u_mem.mem[{pg, 8'h01}] = nx;
        u_mem.mem[{pg, 8'h02}] = 8'h00;
        u_mem.mem[{pg, 8'h03}] = ln;
        u_mem.mem[{pg, 8'h04}] = pr;
        u_mem.mem[{pg, 8'h05}] = fl;
        for (i = 0; i < ln; i++) begin
            u_mem.mem[{pg, 8'h06} + 16'(i)] = db + 8'(i);
            exp_q.push_back({i == ln - 1, db + 8'(i)});
        end
    endtask

    task automatic wait_idle(input int n);
        int k;
        for (k = 0; k < 2000 && (got_q.size() < n || tx_busy_out !== 1'b0); k++)
            step();
        step(4);
    endtask

    task automatic t_tx_ring;
        put_pkt(8'h10, 8'h12, 8'h05, 8'h06, 8'h00, 8'hA0);
        put_pkt(8'h12, 8'h13, 8'h03, 8'h11, 8'h80, 8'hB0);
        put_pkt(8'h13, 8'h14, 8'h01, 8'h01, 8'h80, 8'hC0);
        tx_ring_init_in = 1'b1;
        step();
        tx_ring_init_in = 1'b0;
        tx_enqueue_in = 1'b1;
        step();
        tx_enqueue_in = 1'b0;
        `CHK("tx_head", 16'h0010, tx_ring_head_pointer_out)
        `CHK("tx_free", 8'h0C, tx_ring_free_pages_out)
        stall_until = cyc + 40;
        tx_tag_enable_in = 1'b1;
        tx_tail_pointer_in = 16'h0013;
        tx_enable_in = 1'b1;
        wait_idle(8);
        `CHK("tx_busy", 1'b0, tx_busy_out)
        `CHK("tx_head", 16'h0013, tx_ring_head_pointer_out)
        `CHK("tx_free", 8'h0F, tx_ring_free_pages_out)
        tx_llc_header_enable_in = 1'b1;
        tx_tail_pointer_in = 16'h0014;
        wait_idle(9);
        `CHK("tx_head", 16'h0014, tx_ring_head_pointer_out)
        `CHK("tx_free", 8'h10, tx_ring_free_pages_out)
        `CHK("mac_count", 32'd9, got_q.size())
        foreach (exp_q[k]) `CHK("mac_byte", exp_q[k], got_q[k])
        `CHK("hdr_a", 16'h0612, par_q[0])
        `CHK("hdr_b", 16'h11B0, par_q[1])
        `CHK("hdr_c", 16'h01B1, par_q[2])
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        step(16);
        sys_rst_in = 1'b0;
        t_rx_class();
        t_rx_wrap();
        t_tx_ring();
        complete_run();
    end
endmodule // orph_packet_headers_tb_top
`default_nettype wire
